/* File: include/ced_pkg.sv */
// Constants and carrier types for the low-priority exception dispatcher
package ced_pkg;

   // ===========================================================
   // Vectors and cause codes
   localparam logic [31:0] CED_GEN_OFFSET     = 32'h0000_0180;
   localparam logic [31:0] CED_DBG_VEC_NOPROBE = 32'hBFC0_0480;
   localparam logic [31:0] CED_DBG_VEC_PROBE   = 32'hBFC0_0200;
   localparam logic [4:0]  CED_CODE_COPRO     = 5'h0B;
   localparam logic [4:0]  CED_CODE_RSVD      = 5'h0A;
   localparam logic [4:0]  CED_CODE_WRAP      = 5'h0C;
   localparam logic [4:0]  CED_CODE_TRAP      = 5'h0D;
   localparam logic [4:0]  CED_CODE_STMIS     = 5'h05;
   localparam logic [4:0]  CED_CODE_BUSERR    = 5'h07;

   // ===========================================================
   // Register map (word offsets in bytes)
   localparam logic [7:0]  CED_REG_CAUSE      = 8'h00;
   localparam logic [7:0]  CED_REG_STATUS     = 8'h04;
   localparam logic [7:0]  CED_REG_DEBUG      = 8'h08;
   localparam logic [7:0]  CED_REG_CTRL       = 8'h0C;
   localparam logic [7:0]  CED_REG_VBASE      = 8'h10;
   localparam logic [7:0]  CED_REG_IRQ_STAT   = 8'h14;
   localparam logic [7:0]  CED_REG_IRQ_EN     = 8'h18;
   localparam logic [7:0]  CED_REG_IRQ_CLR    = 8'h1C;

   // Field positions
   localparam int CED_ST_LVL_BIT   = 0;
   localparam int CED_ST_COP_LSB   = 28;
   localparam int CED_DBG_LW_BIT   = 0;
   localparam int CED_DBG_SW_BIT   = 1;
   localparam int CED_DBG_IF_BIT   = 2;
   localparam int CED_DBG_IL_BIT   = 3;
   localparam int CED_DBG_IS_BIT   = 4;
   localparam int CED_CTL_PROBE_BIT = 0;
   localparam int CED_IRQ_GEN_BIT  = 0;
   localparam int CED_IRQ_DBG_BIT  = 1;

   // Reset values
   localparam logic [31:0] CED_VBASE_RST      = 32'h9FC0_0000;
   localparam logic [31:0] CED_ZERO32         = 32'h0000_0000;

   // ===========================================================
   // Carriers
   typedef struct packed {
      logic       copro_unusable;
      logic [1:0] copro_num;
      logic       reserved_opcode;
      logic       math_wrap;
      logic       trap_true;
      logic       data_break;
      logic       data_break_store;
      logic       store_misalign;
      logic       bus_error;
      logic       complex_break;
      logic [2:0] complex_kind;   // fetch, load, store
   } ced_cond_t;

   typedef struct packed {
      logic        valid;
      logic        debug;
      logic [31:0] vector;
      logic [4:0]  code;
   } ced_disp_t;

   typedef enum logic [3:0] {
      CED_K_NONE   = 4'h0,
      CED_K_COPRO  = 4'h1,
      CED_K_RSVD   = 4'h2,
      CED_K_WRAP   = 4'h3,
      CED_K_TRAP   = 4'h4,
      CED_K_LDBRK  = 4'h5,
      CED_K_STBRK  = 4'h6,
      CED_K_STMIS  = 4'h7,
      CED_K_BUSERR = 4'h8,
      CED_K_COMPLEX_BREAK   = 4'h9
   } ced_kind_t;

endpackage : ced_pkg

/* File: rtl/ced_dispatch.sv */
// Priority selection and dispatch of low-priority core exceptions
`timescale 1ns/1ps

// How it works
// - Disabled coprocessor: 0x180, select+level flags, 0x0B
// - Undefined opcode: 0x180, level flag only, 0x0A
// - Signed overflow: 0x180, EXCEPTION_LEVEL_FLAG, code 0x0C
// - True trap: 0x180, EXCEPTION_LEVEL_FLAG, code 0x0D
// - Misaligned store: 0x180, EXCEPTION_LEVEL_FLAG, code 0x05
// - Data bus error: 0x180, EXCEPTION_LEVEL_FLAG, code 0x07
// - Load data break: probe-dependent debug vector
// - Store data break: same debug vectors
// - Data break sets load or store flag
// - Complex break: debug vector, imprecise flags
// - Fixed priority, complex break lowest
module ced_dispatch
(
   input  wire logic              clk_in,
   input  wire logic              reset_n_in,
   input  wire ced_pkg::ced_cond_t cond_in,
   input  wire logic              handler_ack_in,
   input  wire logic [7:0]        reg_addr_in,
   input  wire logic [31:0]       reg_wdata_in,
   input  wire logic              reg_wr_in,
   input  wire logic              reg_rd_in,
   output logic                   disp_valid_out,
   output logic                   disp_debug_out,
   output logic [31:0]            disp_vector_out,
   output logic [31:0]            reg_rdata_out,
   output logic                   irq_out
);
   import ced_pkg::*;

   // ===========================================================
   // Priority encoder
   ced_kind_t kind;

   always_comb
   begin
      kind = CED_K_NONE;
      if (cond_in.copro_unusable)                            kind = CED_K_COPRO;
      else if (cond_in.reserved_opcode)                      kind = CED_K_RSVD;
      else if (cond_in.math_wrap)                            kind = CED_K_WRAP;
      else if (cond_in.trap_true)                            kind = CED_K_TRAP;
      else if (cond_in.data_break && !cond_in.data_break_store) kind = CED_K_LDBRK;
      else if (cond_in.data_break &&  cond_in.data_break_store) kind = CED_K_STBRK;
      else if (cond_in.store_misalign)                       kind = CED_K_STMIS;
      else if (cond_in.bus_error)                            kind = CED_K_BUSERR;
      else if (cond_in.complex_break)                        kind = CED_K_COMPLEX_BREAK;
   end

   // ===========================================================
   // Architectural state
   logic [31:0] vbase_ff;
   logic        probe_en_ff;
   logic        lvl_ff;
   logic [3:0]  cop_sel_ff;
   logic [4:0]  cause_ff;
   logic [4:0]  dbg_ff;
   logic [1:0]  irq_stat_ff;
   logic [1:0]  irq_en_ff;
   ced_disp_t   nxt_disp;

   logic [31:0] dbg_vec;
   assign dbg_vec = probe_en_ff ? CED_DBG_VEC_PROBE : CED_DBG_VEC_NOPROBE;

   // Carry out of the top bit is dropped on purpose: the vector wraps
   logic [31:0] gen_vec;
   assign gen_vec = 32'(vbase_ff + CED_GEN_OFFSET);

   // Vector and code lookup; one exception taken per cycle
   always_comb
   begin
      nxt_disp = '{valid: 1'b0, debug: 1'b0, vector: CED_ZERO32, code: 5'h00};
      unique case (kind)
         CED_K_NONE: ;
         CED_K_COPRO:  nxt_disp = '{1'b1, 1'b0, gen_vec, CED_CODE_COPRO};
         CED_K_RSVD:   nxt_disp = '{1'b1, 1'b0, gen_vec, CED_CODE_RSVD};
         CED_K_WRAP:   nxt_disp = '{1'b1, 1'b0, gen_vec, CED_CODE_WRAP};
         CED_K_TRAP:   nxt_disp = '{1'b1, 1'b0, gen_vec, CED_CODE_TRAP};
         CED_K_LDBRK:  nxt_disp = '{1'b1, 1'b1, dbg_vec, 5'h00};
         CED_K_STBRK:  nxt_disp = '{1'b1, 1'b1, dbg_vec, 5'h00};
         CED_K_STMIS:  nxt_disp = '{1'b1, 1'b0, gen_vec, CED_CODE_STMIS};
         CED_K_BUSERR: nxt_disp = '{1'b1, 1'b0, gen_vec, CED_CODE_BUSERR};
         CED_K_COMPLEX_BREAK:   nxt_disp = '{1'b1, 1'b1, dbg_vec, 5'h00};
         default:      nxt_disp = '{valid: 1'b0, debug: 1'b0, vector: CED_ZERO32, code: 5'h00};
      endcase
   end

   // ===========================================================
   // Dispatch outputs, one-cycle pulse per taken exception
   always_ff @(posedge clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         disp_valid_out  <= 1'b0;
         disp_debug_out  <= 1'b0;
         disp_vector_out <= CED_ZERO32;
      end
      else
      begin
         disp_valid_out  <= nxt_disp.valid;
         disp_debug_out  <= nxt_disp.debug;
         disp_vector_out <= nxt_disp.vector;
      end
   end

   logic gen_take;
   logic wr_status;
   logic wr_debug;
   logic wr_ctrl;
   logic wr_vbase;
   logic wr_irq_en;
   logic wr_irq_clr;
   assign gen_take   = nxt_disp.valid && !nxt_disp.debug;
   assign wr_status  = reg_wr_in && (reg_addr_in == CED_REG_STATUS);
   assign wr_debug   = reg_wr_in && (reg_addr_in == CED_REG_DEBUG);
   assign wr_ctrl    = reg_wr_in && (reg_addr_in == CED_REG_CTRL);
   assign wr_vbase   = reg_wr_in && (reg_addr_in == CED_REG_VBASE);
   assign wr_irq_en  = reg_wr_in && (reg_addr_in == CED_REG_IRQ_EN);
   assign wr_irq_clr = reg_wr_in && (reg_addr_in == CED_REG_IRQ_CLR);

   // Level flag; hardware set beats a software write in the same cycle
   always_ff @(posedge clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
         lvl_ff <= 1'b0;
      else
      begin
         if (wr_status)
            lvl_ff <= reg_wdata_in[CED_ST_LVL_BIT];
         if (gen_take)
            lvl_ff <= 1'b1;
      end
   end

   // Coprocessor select bits; the faulting unit's bit beats a write
   always_ff @(posedge clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
         cop_sel_ff <= 4'h0;
      else
      begin
         if (wr_status)
            cop_sel_ff <= reg_wdata_in[CED_ST_COP_LSB +: 4];
         if (kind == CED_K_COPRO)
            cop_sel_ff[cond_in.copro_num] <= 1'b1;
      end
   end

   // cause code held for the handler
   always_ff @(posedge clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
         cause_ff <= 5'h00;
      else if (gen_take)
         cause_ff <= nxt_disp.code;
   end

   // Debug flags: cleared by writing ones, a new break wins
   always_ff @(posedge clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
         dbg_ff <= 5'h00;
      else
      begin
         if (wr_debug)
            dbg_ff <= dbg_ff & ~reg_wdata_in[4:0];
         if (kind == CED_K_LDBRK)
            dbg_ff[CED_DBG_LW_BIT] <= 1'b1;
         if (kind == CED_K_STBRK)
            dbg_ff[CED_DBG_SW_BIT] <= 1'b1;
         if (kind == CED_K_COMPLEX_BREAK)
         begin
            if (cond_in.complex_kind[0])
               dbg_ff[CED_DBG_IF_BIT] <= 1'b1;
            if (cond_in.complex_kind[1])
               dbg_ff[CED_DBG_IL_BIT] <= 1'b1;
            if (cond_in.complex_kind[2])
               dbg_ff[CED_DBG_IS_BIT] <= 1'b1;
         end
      end
   end

   // ===========================================================
   // Software configuration; a new base applies to the next exception
   always_ff @(posedge clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
         vbase_ff <= CED_VBASE_RST;
      else if (wr_vbase)
         vbase_ff <= reg_wdata_in;
   end

   always_ff @(posedge clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
         probe_en_ff <= 1'b0;
      else if (wr_ctrl)
         probe_en_ff <= reg_wdata_in[CED_CTL_PROBE_BIT];
   end

   always_ff @(posedge clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
         irq_en_ff <= 2'b00;
      else if (wr_irq_en)
         irq_en_ff <= reg_wdata_in[1:0];
   end

   // ===========================================================
   // Interrupt: sticky events, write-one-to-clear, set wins
   logic [1:0] irq_set;
   assign irq_set = {nxt_disp.valid && nxt_disp.debug, gen_take};

   always_ff @(posedge clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
         irq_stat_ff <= 2'b00;
      else if (wr_irq_clr)
         irq_stat_ff <= (irq_stat_ff & ~reg_wdata_in[1:0]) | irq_set;
      else
         irq_stat_ff <= irq_stat_ff | irq_set;
   end

   always_ff @(posedge clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
         irq_out <= 1'b0;
      else
         irq_out <= |(irq_stat_ff & irq_en_ff);
   end

   // ===========================================================
   // Register read, data valid one cycle after the strobe
   logic [31:0] nxt_rdata;
   always_comb
   begin
      nxt_rdata = CED_ZERO32;
      unique case (reg_addr_in)
         CED_REG_CAUSE:    nxt_rdata = {25'h0, cause_ff, 2'b00};
         CED_REG_STATUS:   nxt_rdata = {cop_sel_ff, 27'h0, lvl_ff};
         CED_REG_DEBUG:    nxt_rdata = {27'h0, dbg_ff};
         CED_REG_CTRL:     nxt_rdata = {31'h0, probe_en_ff};
         CED_REG_VBASE:    nxt_rdata = vbase_ff;
         CED_REG_IRQ_STAT: nxt_rdata = {30'h0, irq_stat_ff};
         CED_REG_IRQ_EN:   nxt_rdata = {30'h0, irq_en_ff};
         default:          nxt_rdata = CED_ZERO32;
      endcase
   end

   always_ff @(posedge clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
         reg_rdata_out <= CED_ZERO32;
      else if (reg_rd_in)
         reg_rdata_out <= nxt_rdata;
      else
         reg_rdata_out <= CED_ZERO32;
   end

endmodule : ced_dispatch

/* File: test/ced_pipe_model.sv */
// Pipeline stand-in that raises exception conditions
`timescale 1ns/1ps
module ced_pipe_model
(
   input  wire logic               clk_in,
   input  wire logic               reset_n_in,
   input  wire ced_pkg::ced_cond_t cmd_in,
   output ced_pkg::ced_cond_t      cond_out
);
   import ced_pkg::*;
   // Registered like a real retire stage, so conditions never glitch mid-cycle
   always_ff @(posedge clk_in or negedge reset_n_in)
      if (!reset_n_in)
         cond_out <= '0;
      else
         cond_out <= cmd_in;
endmodule : ced_pipe_model

/* File: test/ced_dispatch_properties.sv */
// Assertions on the exception dispatcher ports
`timescale 1ns/1ps
module ced_dispatch_chk
(
   input wire logic               clk_in,
   input wire logic               reset_n_in,
   input wire ced_pkg::ced_cond_t cond_in,
   input wire logic               handler_ack_in,
   input wire logic [7:0]         reg_addr_in,
   input wire logic [31:0]        reg_wdata_in,
   input wire logic               reg_wr_in,
   input wire logic               reg_rd_in,
   input wire logic               disp_valid_out,
   input wire logic               disp_debug_out,
   input wire logic [31:0]        disp_vector_out,
   input wire logic [31:0]        reg_rdata_out,
   input wire logic               irq_out
);
   import ced_pkg::*;
   logic [31:0] vb_ff;
   logic        probe_ff;
   logic [4:0]  cause_ff;
   logic        any_c;
   logic        gen_c;
   // ==========================================================
   // Shadow of base and probe; a data break outranks misalign and bus error
   assign any_c = |{cond_in.copro_unusable, cond_in.reserved_opcode, cond_in.math_wrap,
      cond_in.trap_true, cond_in.data_break, cond_in.store_misalign, cond_in.bus_error,
      cond_in.complex_break};
   assign gen_c = |{cond_in.copro_unusable, cond_in.reserved_opcode, cond_in.math_wrap,
      cond_in.trap_true} | (!cond_in.data_break & (cond_in.store_misalign | cond_in.bus_error));
   always_ff @(posedge clk_in or negedge reset_n_in)
      if (!reset_n_in)
         {vb_ff, probe_ff} <= {CED_VBASE_RST, 1'b0};
      else if (reg_wr_in && reg_addr_in == CED_REG_VBASE)
         vb_ff <= reg_wdata_in;
      else if (reg_wr_in && reg_addr_in == CED_REG_CTRL)
         probe_ff <= reg_wdata_in[CED_CTL_PROBE_BIT];
   // Expected cause code, picked by priority among the general kinds
   always_ff @(posedge clk_in or negedge reset_n_in)
      if (!reset_n_in)
         cause_ff <= 5'h00;
      else if (gen_c)
         cause_ff <= cond_in.copro_unusable ? CED_CODE_COPRO
            : cond_in.reserved_opcode ? CED_CODE_RSVD : cond_in.math_wrap ? CED_CODE_WRAP
            : cond_in.trap_true ? CED_CODE_TRAP : cond_in.store_misalign ? CED_CODE_STMIS
            : CED_CODE_BUSERR;
   default clocking @(posedge clk_in);
   endclocking
   default disable iff (!reset_n_in);
   valid_pulse_a: assert property (any_c |=> disp_valid_out)
      else $error("condition without dispatch");
   idle_quiet_a: assert property (!any_c |=> !disp_valid_out && disp_vector_out == 32'h0)
      else $error("dispatch without condition");
   gen_vector_a: assert property (gen_c |=> !disp_debug_out
      && disp_vector_out == $past(vb_ff) + CED_GEN_OFFSET) else $error("general vector wrong");
   dbg_vector_a: assert property (any_c && !gen_c |=> disp_debug_out
      && disp_vector_out == ($past(probe_ff) ? CED_DBG_VEC_PROBE : CED_DBG_VEC_NOPROBE))
      else $error("debug vector wrong");
   debug_valid_a: assert property (disp_debug_out |-> disp_valid_out)
      else $error("debug flag without dispatch");
   rdata_idle_a: assert property (!reg_rd_in |=> reg_rdata_out == 32'h0)
      else $error("read data outside read");
   vbase_read_a: assert property (reg_rd_in && reg_addr_in == CED_REG_VBASE |=>
      reg_rdata_out == $past(vb_ff)) else $error("base readback wrong");
   cause_field_a: assert property (reg_rd_in && reg_addr_in == CED_REG_CAUSE |=>
      reg_rdata_out == {25'h0, $past(cause_ff), 2'b00}) else $error("cause readback wrong");
   cover property (gen_c);
   cover property (any_c && !gen_c && probe_ff);
   cover property (irq_out);
endmodule : ced_dispatch_chk

bind ced_dispatch ced_dispatch_chk u_chk (.clk_in, .reset_n_in, .cond_in, .handler_ack_in,
   .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in, .disp_valid_out, .disp_debug_out,
   .disp_vector_out, .reg_rdata_out, .irq_out);

/* File: test/core_exception_dispatch_tb_top.sv */
// Self-checking bench for the exception dispatcher
`timescale 1ns/1ps
module core_exception_dispatch_tb_top;
   import ced_pkg::*;
   logic        clk_in = 1'b0;
   logic        reset_n_in = 1'b0;
   ced_cond_t   cmd = '0;
   ced_cond_t   cond;
   logic [7:0]  addr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic        wr = 1'b0;
   logic        rd = 1'b0;
   logic        valid, dbg, irq, gen;
   logic [31:0] vec, rdata, exp_v;
   logic [31:0] vb = 32'h8000_1000;
   logic [4:0]  last = 5'h00;
   logic [4:0]  codes [9] = '{5'h0B, 5'h0A, 5'h0C, 5'h0D, 5'h00, 5'h00, 5'h05, 5'h07, 5'h00};
   int          n_errors = 0;
   int          checked = 0;
   int          cycles = 0;
   always #20 clk_in = ~clk_in;
   ced_pipe_model u_pipe (.clk_in, .reset_n_in, .cmd_in(cmd), .cond_out(cond));
   ced_dispatch u_dut (.clk_in, .reset_n_in, .cond_in(cond), .handler_ack_in(1'b0),
      .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
      .disp_valid_out(valid), .disp_debug_out(dbg), .disp_vector_out(vec),
      .reg_rdata_out(rdata), .irq_out(irq));
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic results;
      if (n_errors == 0 && checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : results
   // One bus cycle; a read compares the data standing in the next cycle
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input string s);
      @(posedge clk_in);
      addr <= a;
      wdata <= d;
      wr <= w;
      rd <= !w;
      @(posedge clk_in);
      wr <= 1'b0;
      rd <= 1'b0;
      #1;
      if (!w)
         chk(s, rdata, d);
   endtask : bus
   task automatic fire(input ced_cond_t c);
      @(posedge clk_in);
      cmd <= c;
      @(posedge clk_in);
      cmd <= '0;
      @(posedge clk_in);
      #1;
   endtask : fire
   task automatic irq_is(input logic e);
      @(posedge clk_in);
      #1;
      chk("irq", {31'h0, irq}, {31'h0, e});
   endtask : irq_is
   // Kind k with every lower-priority condition except the store break when k is 4 or less; pass p varies unit and break kind
   function automatic ced_cond_t mk(input int k, input int p);
      logic [8:0] b;
      b = 9'h1FF << k;
      return '{b[0], 2'(p + 2), b[1], b[2], b[3], b[4] | b[5], b[5] & ~b[4], b[6], b[7], b[8],
         p ? 3'b010 : 3'b101};
   endfunction : mk
   always @(posedge clk_in)
   begin
      cycles++;
      if (cycles == 2000)
      begin
         n_errors++;
         results();
      end
   end
   initial
   begin
      repeat (3) @(posedge clk_in);
      reset_n_in <= 1'b1;
      bus(1'b0, CED_REG_VBASE, CED_VBASE_RST, "vbase_rst");
      bus(1'b0, 8'h20, 32'h0, "unmapped");
      bus(1'b1, CED_REG_VBASE, vb, "");
      for (int p = 0; p < 2; p++)
      begin
         bus(1'b1, CED_REG_CTRL, 32'(p), "");
         for (int k = 0; k < 9; k++)
         begin
            gen = !(k inside {4, 5, 8});
            exp_v = gen ? vb + CED_GEN_OFFSET : (p ? CED_DBG_VEC_PROBE : CED_DBG_VEC_NOPROBE);
            if (gen)
               last = codes[k];
            fire(mk(k, p));
            chk("valid", {31'h0, valid}, 32'h1);
            chk("debug", {31'h0, dbg}, {31'h0, !gen});
            chk("vector", vec, exp_v);
            bus(1'b0, CED_REG_CAUSE, {25'h0, last, 2'b00}, "cause");
            bus(1'b0, CED_REG_STATUS, !gen ? 32'h0 : k != 0 ? 32'h1 : p ? 32'h8000_0001
               : 32'h4000_0001, "status");
            bus(1'b0, CED_REG_DEBUG, k == 4 ? 32'h1 : k == 5 ? 32'h2 : k != 8 ? 32'h0 : p ? 32'h8
               : 32'h14, "dbg_flags");
            bus(1'b1, CED_REG_STATUS, 32'h0, "");
            bus(1'b1, CED_REG_DEBUG, 32'h1F, "");
         end
      end
      bus(1'b0, CED_REG_IRQ_STAT, 32'h3, "irq_stat");
      irq_is(1'b0);
      bus(1'b1, CED_REG_IRQ_EN, 32'h1, "");
      irq_is(1'b1);
      bus(1'b1, CED_REG_IRQ_CLR, 32'h1, "");
      irq_is(1'b0);
      bus(1'b1, CED_REG_IRQ_EN, 32'h3, "");
      irq_is(1'b1);
      bus(1'b1, CED_REG_IRQ_CLR, 32'h2, "");
      irq_is(1'b0);
      bus(1'b0, CED_REG_IRQ_STAT, 32'h0, "irq_clr");
      results();
   end
endmodule : core_exception_dispatch_tb_top
